// file: hdl/dram_power_refresh_config.sv
`timescale 1ns/1ps
`default_nettype none
module dram_power_refresh_config #(
   parameter bit HOT_GRADE = 1'b0
) (
   input wire logic clock_i,                 // System clock, 50 MHz
   input wire logic srst_i,                  // Power-on reset, sync
   input wire logic cs_n_i,                  // Chip select pin
   input wire logic link_clk_i,              // Bus clock pin
   input wire logic hw_reset_n_i,            // Hardware reset pin
   input wire logic [12:0] access_row_i,     // Row of current access
   input wire logic cfg_wr_i,                // Register write strobe
   input wire logic cfg_rd_i,                // Register read strobe
   input wire logic cfg_sel_i,               // 0 first, 1 second reg
   input wire logic [15:0] cfg_wdata_i,      // Register write data
   output logic [15:0] cfg_rdata_o,          // Register read data
   output logic rw_data_strobe_o,            // Strobe level driven
   output logic rw_data_strobe_oe_n_o,       // Strobe enable, low drives
   output logic latency_double_o,            // Two latency periods
   output logic deep_power_down_o,           // In deep power-down
   output logic hybrid_sleep_o,              // In hybrid sleep
   output logic clock_complement_en_o,       // Complement clock in use
   output logic array_valid_o,               // Array contents valid
   output logic refresh_strobe_o,            // One row refreshed
   output logic [12:0] refresh_row_o,        // Row being refreshed
   output logic row_writeback_o,             // Access row written back
   output logic [12:0] writeback_row_o       // Row written back
);

   // ==========================================================
   // Decoding
   function automatic logic row_in_window(input logic [2:0] par,
                                          input logic [12:0] row);
      logic hit;
      hit = 1'b1;
      case (par)
         dram_cfg_pkg::PAR_BOT_HALF: hit = ~row[12];
         dram_cfg_pkg::PAR_BOT_QUARTER: hit = (row[12:11] == 2'h0);
         dram_cfg_pkg::PAR_BOT_EIGHTH: hit = (row[12:10] == 3'h0);
         dram_cfg_pkg::PAR_NONE: hit = 1'b0;
         dram_cfg_pkg::PAR_TOP_HALF: hit = row[12];
         dram_cfg_pkg::PAR_TOP_QUARTER: hit = (row[12:11] == 2'h3);
         default: hit = 1'b1; // full array, and reserved 111
      endcase
      return hit;
   endfunction

   function automatic logic write_to(input logic wr, input logic sel,
                                     input logic which);
      return wr && (sel == which);
   endfunction

   // ==========================================================
   // Pin synchronisers
   logic [2:0] pin_raw;
   logic [2:0] pin_f;
   assign pin_raw = {hw_reset_n_i, link_clk_i, cs_n_i};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         logic s1, s2, s3, filt;
         always_ff @(posedge clock_i) begin
            if (srst_i) begin
               s1 <= dram_cfg_pkg::PIN_IDLE[g];
               s2 <= dram_cfg_pkg::PIN_IDLE[g];
               s3 <= dram_cfg_pkg::PIN_IDLE[g];
               filt <= dram_cfg_pkg::PIN_IDLE[g];
            end else begin
               s1 <= pin_raw[g];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3) begin
                  filt <= s3;
               end
            end
         end
         assign pin_f[g] = filt;
      end
   endgenerate

   logic cs_f, ck_f, hw_rst, rst_all;
   logic cs_prev, ck_prev, cs_fall, cs_rise, ck_rise;
   assign cs_f = pin_f[0];
   assign ck_f = pin_f[1];
   assign hw_rst = ~pin_f[2];
   assign rst_all = srst_i | hw_rst;
   assign cs_fall = cs_prev & ~cs_f;
   assign cs_rise = ~cs_prev & cs_f;
   assign ck_rise = ~ck_prev & ck_f;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cs_prev <= 1'b1;
         ck_prev <= 1'b0;
      end else begin
         cs_prev <= cs_f;
         ck_prev <= ck_f;
      end
   end

   // ==========================================================
   // Power state
   dram_cfg_pkg::power_state_t state;
   logic [7:0] entry_cnt;
   logic seen_low;
   logic wr_first, wr_second, regs_open;
   assign regs_open = (state == dram_cfg_pkg::ST_ACTIVE);
   // Writes ignored while powered down
   assign wr_first = regs_open &&
      write_to(cfg_wr_i, cfg_sel_i, dram_cfg_pkg::REG_SEL_FIRST);
   assign wr_second = regs_open &&
      write_to(cfg_wr_i, cfg_sel_i, dram_cfg_pkg::REG_SEL_SECOND);

   always_ff @(posedge clock_i) begin
      if (rst_all) begin // resets end both low-power states
         state <= dram_cfg_pkg::ST_ACTIVE;
         entry_cnt <= 8'h00;
         seen_low <= 1'b0;
      end else begin
         case (state)
            dram_cfg_pkg::ST_ACTIVE: begin
               if (wr_first && !cfg_wdata_i[dram_cfg_pkg::CR0_DPD_BIT]) begin
                  state <= dram_cfg_pkg::ST_DPD_ENTRY;
                  entry_cnt <= 8'(dram_cfg_pkg::DPD_ENTRY_CYC - 1);
               end else if (wr_second &&
                            cfg_wdata_i[dram_cfg_pkg::CR1_SLEEP_BIT]) begin
                  state <= dram_cfg_pkg::ST_SLEEP;
               end
            end
            dram_cfg_pkg::ST_DPD_ENTRY: begin
               if (entry_cnt == 8'h00) begin
                  state <= dram_cfg_pkg::ST_DPD;
                  seen_low <= 1'b0;
               end else begin
                  entry_cnt <= entry_cnt - 8'h01;
               end
            end
            dram_cfg_pkg::ST_DPD: begin
               // Only select is watched here
               if (!cs_f) begin
                  seen_low <= 1'b1;
               end else if (seen_low) begin
                  state <= dram_cfg_pkg::ST_ACTIVE;
               end
            end
            dram_cfg_pkg::ST_SLEEP: begin
               if (cs_fall) begin
                  state <= dram_cfg_pkg::ST_ACTIVE;
               end
            end
            default: state <= dram_cfg_pkg::ST_ACTIVE;
         endcase
      end
   end

   // ==========================================================
   // Configuration registers
   logic dpd_bit;
   logic [7:0] rsvd_hi;
   logic clk_type, sleep_bit;
   logic [2:0] par;
   logic [1:0] intv_code;
   assign intv_code = HOT_GRADE ? dram_cfg_pkg::INTV_1US
                                : dram_cfg_pkg::INTV_4US;

   always_ff @(posedge clock_i) begin
      if (rst_all) begin
         dpd_bit <= 1'b1;
         rsvd_hi <= dram_cfg_pkg::CR1_RSVD_HI_RESET;
         clk_type <= dram_cfg_pkg::CR1_CLK_TYPE_RESET;
         par <= dram_cfg_pkg::PAR_FULL;
      end else begin
         if (wr_first) begin
            dpd_bit <= cfg_wdata_i[dram_cfg_pkg::CR0_DPD_BIT];
         end else if (state == dram_cfg_pkg::ST_DPD && cs_f && seen_low) begin
            dpd_bit <= 1'b1;
         end
         if (wr_second) begin
            rsvd_hi <= cfg_wdata_i[dram_cfg_pkg::CR1_RSVD_HI_MSB:
                                   dram_cfg_pkg::CR1_RSVD_HI_LSB];
            clk_type <= cfg_wdata_i[dram_cfg_pkg::CR1_CLK_TYPE_BIT];
            par <= cfg_wdata_i[dram_cfg_pkg::CR1_PAR_MSB:
                               dram_cfg_pkg::CR1_PAR_LSB];
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_all) begin
         sleep_bit <= dram_cfg_pkg::CR1_SLEEP_RESET;
      end else if (wr_second) begin
         sleep_bit <= cfg_wdata_i[dram_cfg_pkg::CR1_SLEEP_BIT];
      end else if (state == dram_cfg_pkg::ST_SLEEP && cs_fall) begin
         sleep_bit <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_all) begin
         cfg_rdata_o <= 16'h0000;
      end else if (cfg_rd_i && regs_open) begin
         if (cfg_sel_i == dram_cfg_pkg::REG_SEL_SECOND) begin
            cfg_rdata_o <= {rsvd_hi, dram_cfg_pkg::CR1_RSVD_RESET,
                            clk_type, sleep_bit, par, intv_code};
         end else begin
            cfg_rdata_o <= {dpd_bit, 15'h0000};
         end
      end
   end

   // ==========================================================
   // Self-refresh, one row per interval
   localparam logic [8:0] ROW_INTV = HOT_GRADE
      ? 9'(dram_cfg_pkg::ROW_INTV_HOT_CYC)
      : 9'(dram_cfg_pkg::ROW_INTV_STD_CYC);
   logic [8:0] tick_cnt;
   logic tick, pending, ref_on, ref_start, access_on;
   logic [2:0] busy_cnt;
   logic [12:0] row_ptr;
   assign tick = (tick_cnt == 9'h000);
   assign ref_on = (state == dram_cfg_pkg::ST_ACTIVE) ||
                   (state == dram_cfg_pkg::ST_SLEEP);
   assign access_on = !cs_f && (state == dram_cfg_pkg::ST_ACTIVE);
   // Wait for the access to end
   assign ref_start = pending && !access_on && (busy_cnt == 3'h0);

   always_ff @(posedge clock_i) begin
      if (rst_all) begin
         tick_cnt <= ROW_INTV - 9'h001;
         pending <= 1'b0;
      end else begin
         tick_cnt <= tick ? ROW_INTV - 9'h001 : tick_cnt - 9'h001;
         // A new tick wins over the clear by a start
         pending <= ref_on && ((tick) || (pending && !ref_start));
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_all) begin
         busy_cnt <= 3'h0;
         row_ptr <= 13'h0000;
         refresh_strobe_o <= 1'b0;
         refresh_row_o <= 13'h0000;
      end else begin
         refresh_strobe_o <= 1'b0;
         if (ref_start) begin
            // Row pointer always advances to keep the spacing even
            row_ptr <= row_ptr + 13'h0001;
            refresh_row_o <= row_ptr;
            if (row_in_window(par, row_ptr)) begin
               refresh_strobe_o <= 1'b1;
               busy_cnt <= 3'(dram_cfg_pkg::REFRESH_BUSY_CYC);
            end
         end else if (busy_cnt != 3'h0) begin
            busy_cnt <= busy_cnt - 3'h1;
         end
      end
   end

   // ==========================================================
   // Command phase strobe and row write-back
   logic [1:0] ca_cnt;
   always_ff @(posedge clock_i) begin
      if (rst_all) begin
         ca_cnt <= 2'h0;
         rw_data_strobe_o <= 1'b0;
         rw_data_strobe_oe_n_o <= 1'b1;
         latency_double_o <= 1'b0;
      end else if (cs_fall && state == dram_cfg_pkg::ST_ACTIVE) begin
         ca_cnt <= 2'h0;
         rw_data_strobe_oe_n_o <= 1'b0;
         rw_data_strobe_o <= pending || (busy_cnt != 3'h0);
         latency_double_o <= pending || (busy_cnt != 3'h0);
      end else if (cs_rise || !access_on) begin
         rw_data_strobe_oe_n_o <= 1'b1;
         rw_data_strobe_o <= 1'b0;
         latency_double_o <= 1'b0;
      end else if (ck_rise && !rw_data_strobe_oe_n_o) begin
         ca_cnt <= ca_cnt + 2'h1;
         if (ca_cnt == 2'(dram_cfg_pkg::CA_CLOCKS - 1)) begin
            rw_data_strobe_oe_n_o <= 1'b1;
            rw_data_strobe_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_all) begin
         row_writeback_o <= 1'b0;
         writeback_row_o <= 13'h0000;
      end else begin
         row_writeback_o <= cs_rise && state == dram_cfg_pkg::ST_ACTIVE;
         if (cs_rise && state == dram_cfg_pkg::ST_ACTIVE) begin
            writeback_row_o <= access_row_i;
         end
      end
   end

   // ==========================================================
   // Status outputs
   always_ff @(posedge clock_i) begin
      if (rst_all) begin
         deep_power_down_o <= 1'b0;
         hybrid_sleep_o <= 1'b0;
         clock_complement_en_o <= 1'b0;
         array_valid_o <= 1'b0; // reset drops refresh guarantee
      end else begin
         deep_power_down_o <= (state == dram_cfg_pkg::ST_DPD);
         hybrid_sleep_o <= (state == dram_cfg_pkg::ST_SLEEP);
         clock_complement_en_o <= !clk_type;
         if (state == dram_cfg_pkg::ST_DPD) begin
            array_valid_o <= 1'b0;
         end else if (row_writeback_o) begin
            array_valid_o <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i || hw_rst);

   sequence dpd_cs_low_high;
      deep_power_down_o && !cs_f ##[1:100] cs_f;
   endsequence

   dpd_entry_time_a: assert property (wr_first && !cfg_wdata_i[15]
      |-> ##[1:152] deep_power_down_o)
      else $error("deep power-down not reached in time");
   dpd_no_refresh_a: assert property (deep_power_down_o
      |-> !refresh_strobe_o && !array_valid_o)
      else $error("refresh or valid data in deep power-down");
   dpd_exit_a: assert property (dpd_cs_low_high
      |-> ##[1:3] !deep_power_down_o)
      else $error("deep power-down not left after select pulse");
   dpd_strobe_quiet_a: assert property (deep_power_down_o
      |-> rw_data_strobe_oe_n_o)
      else $error("strobe driven in deep power-down");
   clock_type_a: assert property (##1 clock_complement_en_o
      == !$past(clk_type))
      else $error("complement clock enable wrong");
   sleep_exit_a: assert property (hybrid_sleep_o && cs_fall
      |-> ##[1:2] !hybrid_sleep_o ##0 !sleep_bit)
      else $error("hybrid sleep not left on select low");
   refresh_idle_a: assert property (refresh_strobe_o
      |-> $past(!access_on))
      else $error("refresh during host access");
   latency_flag_a: assert property (!rw_data_strobe_oe_n_o
      && rw_data_strobe_o |-> latency_double_o)
      else $error("strobe high without extra latency");
   writeback_a: assert property (cs_rise && state == dram_cfg_pkg::ST_ACTIVE
      |=> row_writeback_o && writeback_row_o == $past(access_row_i))
      else $error("row not written back at access end");

endmodule
`default_nettype wire

// file: hdl/dram_cfg_pkg.sv
package dram_cfg_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int ARRAY_ROWS = 8192;
   localparam int ROW_W = 13;
   localparam int REFI_STD_MS = 64;
   localparam int REFI_HOT_MS = 16;
   // Longest spacing per row, so rounded down
   localparam int ROW_INTV_STD_CYC =
      (REFI_STD_MS * 1000000) / (ARRAY_ROWS * CLK_PERIOD_NS);
   localparam int ROW_INTV_HOT_CYC =
      (REFI_HOT_MS * 1000000) / (ARRAY_ROWS * CLK_PERIOD_NS);
   localparam int DPD_ENTRY_NS = 3000;
   localparam int DPD_ENTRY_CYC = DPD_ENTRY_NS / CLK_PERIOD_NS;
   localparam int REFRESH_BUSY_CYC = 4;
   localparam int CA_CLOCKS = 3;

   // ==========================================================
   // Register select and fields
   localparam logic REG_SEL_FIRST = 1'h0;
   localparam logic REG_SEL_SECOND = 1'h1;
   localparam int CR0_DPD_BIT = 15;
   localparam int CR1_RSVD_HI_MSB = 15;
   localparam int CR1_RSVD_HI_LSB = 8;
   localparam int CR1_RSVD_BIT = 7;
   localparam int CR1_CLK_TYPE_BIT = 6;
   localparam int CR1_SLEEP_BIT = 5;
   localparam int CR1_PAR_MSB = 4;
   localparam int CR1_PAR_LSB = 2;
   localparam logic [7:0] CR1_RSVD_HI_RESET = 8'hFF;
   localparam logic CR1_RSVD_RESET = 1'h1;
   localparam logic CR1_CLK_TYPE_RESET = 1'h1;
   localparam logic CR1_SLEEP_RESET = 1'h0;
   localparam logic [1:0] INTV_4US = 2'h1;
   localparam logic [1:0] INTV_1US = 2'h2;

   localparam logic [2:0] PAR_FULL = 3'h0;
   localparam logic [2:0] PAR_BOT_HALF = 3'h1;
   localparam logic [2:0] PAR_BOT_QUARTER = 3'h2;
   localparam logic [2:0] PAR_BOT_EIGHTH = 3'h3;
   localparam logic [2:0] PAR_NONE = 3'h4;
   localparam logic [2:0] PAR_TOP_HALF = 3'h5;
   localparam logic [2:0] PAR_TOP_QUARTER = 3'h6;

   // Pin order {reset_n, link clock, select_n}, idle levels
   localparam logic [2:0] PIN_IDLE = 3'h5;

   typedef enum logic [1:0] {
      ST_ACTIVE = 2'b00,
      ST_DPD_ENTRY = 2'b01,
      ST_DPD = 2'b10,
      ST_SLEEP = 2'b11
   } power_state_t;

endpackage

// file: test/host_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host controller: select and link clock for one frame
module host_ctrl_model (
   input wire logic clock_i,    // System clock
   input wire logic go_i,       // Start one frame
   input wire logic [7:0] len_i, // Link clock periods in frame
   output logic cs_n_o,         // Chip select pin
   output logic link_clk_o,     // Link clock pin
   output logic busy_o          // Frame in progress
);
   initial begin
      cs_n_o = 1'b1;
      link_clk_o = 1'b0;
      busy_o = 1'b0;
      forever begin
         @(posedge clock_i);
         if (go_i === 1'b1) begin
            busy_o = 1'b1;
            cs_n_o = 1'b0;
            // Odd offset keeps the link clock unrelated in phase
            #37;
            repeat (len_i) begin
               #80 link_clk_o = 1'b1;
               #80 link_clk_o = 1'b0;
            end
            // Clock stands low outside frames
            #80 cs_n_o = 1'b1;
            busy_o = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: test/dram_power_refresh_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dram_power_refresh_config_tb_top;
   // ==========================================================
   // Signals
   logic clock_i, srst_i, hw_reset_n_i, cfg_wr_i, cfg_rd_i, cfg_sel_i;
   logic [12:0] access_row_i, refresh_row_o, writeback_row_o, wb_row;
   logic [15:0] cfg_wdata_i, cfg_rdata_o, d;
   logic rw_data_strobe_o, rw_data_strobe_oe_n_o, latency_double_o;
   logic deep_power_down_o, hybrid_sleep_o, clock_complement_en_o;
   logic array_valid_o, refresh_strobe_o, row_writeback_o;
   logic go, busy, cs_n, link_clk, seen_oe, seen_hi, lat_seen;
   logic [7:0] len;
   int errors, checks, n_ref, c;
   logic [12:0] r0;

   dram_power_refresh_config uut (
      .clock_i(clock_i), .srst_i(srst_i), .cs_n_i(cs_n),
      .link_clk_i(link_clk), .hw_reset_n_i(hw_reset_n_i),
      .access_row_i(access_row_i), .cfg_wr_i(cfg_wr_i),
      .cfg_rd_i(cfg_rd_i), .cfg_sel_i(cfg_sel_i),
      .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
      .rw_data_strobe_o(rw_data_strobe_o),
      .rw_data_strobe_oe_n_o(rw_data_strobe_oe_n_o),
      .latency_double_o(latency_double_o),
      .deep_power_down_o(deep_power_down_o),
      .hybrid_sleep_o(hybrid_sleep_o),
      .clock_complement_en_o(clock_complement_en_o),
      .array_valid_o(array_valid_o),
      .refresh_strobe_o(refresh_strobe_o), .refresh_row_o(refresh_row_o),
      .row_writeback_o(row_writeback_o), .writeback_row_o(writeback_row_o)
   );

   host_ctrl_model host (
      .clock_i(clock_i), .go_i(go), .len_i(len), .cs_n_o(cs_n),
      .link_clk_o(link_clk), .busy_o(busy)
   );

   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end

   // ==========================================================
   // Monitors
   always @(posedge clock_i) begin
      if (refresh_strobe_o === 1'b1) n_ref <= n_ref + 1;
      if (rw_data_strobe_oe_n_o === 1'b0) begin
         seen_oe <= 1'b1;
         if (rw_data_strobe_o === 1'b1) seen_hi <= 1'b1;
      end
      if (latency_double_o === 1'b1) lat_seen <= 1'b1;
      if (row_writeback_o === 1'b1) wb_row <= writeback_row_o;
   end

   // ==========================================================
   // Helpers
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask

   task automatic wr(input logic sel, input logic [15:0] v);
      @(negedge clock_i);
      cfg_sel_i = sel;
      cfg_wdata_i = v;
      cfg_wr_i = 1'b1;
      @(negedge clock_i);
      cfg_wr_i = 1'b0;
   endtask

   task automatic rd(input logic sel, output logic [15:0] v);
      @(negedge clock_i);
      cfg_sel_i = sel;
      cfg_rd_i = 1'b1;
      @(negedge clock_i);
      cfg_rd_i = 1'b0;
      @(negedge clock_i);
      v = cfg_rdata_o;
   endtask

   task automatic frame(input logic [7:0] n);
      @(negedge clock_i);
      seen_oe = 1'b0;
      seen_hi = 1'b0;
      lat_seen = 1'b0;
      len = n;
      go = 1'b1;
      @(negedge clock_i);
      go = 1'b0;
      while (busy === 1'b1) @(negedge clock_i);
   endtask

   // Bounded wait for the next refresh pulse, in cycles
   task automatic wait_ref(output int w);
      int k;
      k = n_ref;
      w = 0;
      while (n_ref == k && w < 1000) begin
         @(negedge clock_i);
         w++;
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rd(1'b1, d);
      chk("second reg", 16'hFFC1, d);
      rd(1'b0, d);
      chk("power bit", 16'h1, 16'(d[15]));
      chk("complement", 16'h0, 16'(clock_complement_en_o));
   endtask

   task automatic t_regs();
      // Differential mode: type bit 0 turns the complement enable on
      wr(1'b1, 16'hFF80);
      rd(1'b1, d);
      chk("clock type", 16'hFF81, d);
      chk("complement", 16'h1, 16'(clock_complement_en_o));
      wr(1'b1, 16'hFFC0);
      rd(1'b1, d);
      chk("complement", 16'h0, 16'(clock_complement_en_o));
   endtask

   task automatic t_par();
      logic [2:0] p;
      logic on;
      for (int i = 0; i < 8; i++) begin
         p = 3'(i);
         on = !(p inside {3'h4, 3'h5, 3'h6});
         wr(1'b1, 16'hFFC0 | 16'({p, 2'h0}));
         rd(1'b1, d);
         chk("par field", 16'(p), 16'(d[4:2]));
         n_ref = 0;
         cyc(800);
         chk("par refresh", 16'(on), 16'(n_ref != 0));
      end
      wr(1'b1, 16'hFFC0);
   endtask

   task automatic t_spacing();
      wait_ref(c);
      r0 = refresh_row_o;
      wait_ref(c);
      chk("spacing", 16'(dram_cfg_pkg::ROW_INTV_STD_CYC), c[15:0]);
      chk("row step", 16'(r0 + 13'h0001), 16'(refresh_row_o));
   endtask

   // Access spans a refresh slot, then a re-select hits the deferred one
   task automatic t_access();
      int k;
      wait_ref(c);
      cyc(300);
      k = n_ref;
      access_row_i = 13'h0ABC;
      frame(8'd20);
      chk("deferred", 16'(k), 16'(n_ref));
      chk("strobe driven", 16'h1, 16'(seen_oe));
      chk("strobe idle", 16'h0, 16'(seen_hi));
      access_row_i = 13'h1555;
      frame(8'd2);
      chk("strobe high", 16'h1, 16'(seen_hi));
      chk("double lat", 16'h1, 16'(lat_seen));
      cyc(10);
      chk("refresh after", 16'(k + 1), 16'(n_ref));
      chk("wb row", 16'(13'h1555), 16'(wb_row));
      chk("array valid", 16'h1, 16'(array_valid_o));
   endtask

   task automatic t_sleep();
      wr(1'b1, 16'hFFE0);
      cyc(4);
      chk("sleep on", 16'h1, 16'(hybrid_sleep_o));
      frame(8'd2);
      cyc(8);
      chk("sleep off", 16'h0, 16'(hybrid_sleep_o));
      chk("no cmd phase", 16'h0, 16'(seen_oe));
      rd(1'b1, d);
      chk("sleep bit", 16'hFFC1, d);
   endtask

   task automatic t_dpd();
      wr(1'b0, 16'h7FFF);
      cyc(dram_cfg_pkg::DPD_ENTRY_CYC + 4);
      chk("dpd on", 16'h1, 16'(deep_power_down_o));
      chk("array valid", 16'h0, 16'(array_valid_o));
      n_ref = 0;
      wr(1'b1, 16'hFF80);
      cyc(800);
      chk("dpd refresh", 16'h0, 16'(n_ref));
      chk("dpd ignores", 16'h0, 16'(clock_complement_en_o));
      frame(8'd2);
      cyc(8);
      chk("dpd off", 16'h0, 16'(deep_power_down_o));
      rd(1'b0, d);
      chk("power bit", 16'h1, 16'(d[15]));
   endtask

   task automatic t_hwreset();
      wr(1'b1, 16'hFFA4);
      cyc(4);
      chk("sleep on", 16'h1, 16'(hybrid_sleep_o));
      hw_reset_n_i = 1'b0;
      cyc(6);
      hw_reset_n_i = 1'b1;
      cyc(6);
      chk("sleep off", 16'h0, 16'(hybrid_sleep_o));
      chk("array valid", 16'h0, 16'(array_valid_o));
      rd(1'b1, d);
      chk("second reg", 16'hFFC1, d);
   endtask

   task automatic end_sim();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      #400000;
      errors++;
      end_sim();
   end

   initial begin
      errors = 0;
      checks = 0;
      n_ref = 0;
      srst_i = 1'b1;
      hw_reset_n_i = 1'b1;
      cfg_wr_i = 1'b0;
      cfg_rd_i = 1'b0;
      cfg_sel_i = 1'b0;
      cfg_wdata_i = 16'h0;
      access_row_i = 13'h0;
      go = 1'b0;
      len = 8'h0;
      cyc(3);
      srst_i = 1'b0;
      cyc(6);
      t_reset();
      t_regs();
      t_par();
      t_spacing();
      t_access();
      t_sleep();
      t_dpd();
      t_hwreset();
      end_sim();
   end
endmodule
`default_nettype wire
